//--- hdl/rrlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rrlc_top #(
  parameter int CONFIRM_CYCLES = rrlc_pkg::CONFIRM_CYC
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [3:0]                interface_sel_i,
  input  wire logic [rrlc_pkg::ID_W-1:0] unit_identity_i,
  input  wire logic                      prog_valid_i,
  input  wire logic [6:0]                prog_data_i,
  input  wire logic                      host_rx_i,
  input  wire logic                      mdrop_rx_i,
  input  wire logic                      cmd_valid_i,
  input  wire logic [rrlc_pkg::ID_W-1:0] cmd_addr_i,
  input  wire logic                      cmd_bcast_i,
  input  wire rrlc_pkg::rrlc_cmd_t       cmd_i,
  input  wire logic [rrlc_pkg::PW_W-1:0] cmd_pw_i,
  input  wire logic                      reply_req_i,
  input  wire logic [4:0]                panel_keys_i,
  output logic                           mdrop_tx_o,
  output logic                           mdrop_tx_oe_o,
  output logic                           reply_en_o,
  output logic                           cmd_exec_o,
  output logic                           recall_stb_o,
  output logic                           recall_in_o,
  output logic                           recall_xo_o,
  output logic [5:0]                     recall_num_o,
  output logic [4:0]                     panel_keys_o,
  output logic                           locked_o,
  output logic                           shadow_led_o,
  output logic                           lock_show_o,
  output logic                           unlock_show_o
);
  import rrlc_pkg::*;

  // -----------------------------------------------------------------
  // Configuration decode
  // -----------------------------------------------------------------
  function automatic logic is_master(input logic [3:0] sel);
    is_master = (sel <= IF_MASTER_HI) || (sel == IF_MASTER_WL);
  endfunction

  function automatic logic is_slave(input logic [3:0] sel);
    is_slave = (sel >= IF_SLAVE_LO) && (sel <= IF_SLAVE_HI);
  endfunction

  logic            master_w;
  logic            shadow_w;
  logic [ID_W-1:0] main_id_w;
  logic            addr_hit_w;
  logic            run_w;

  always_comb begin
    master_w  = is_master(interface_sel_i);
    // Identities past 32 are shadows, renumbered from 01, slave only.
    shadow_w  = is_slave(interface_sel_i) && (unit_identity_i > ID_MAIN_MAX);
    main_id_w = shadow_w ? ID_W'(unit_identity_i - ID_MAIN_MAX) : unit_identity_i;
    // A shadow matches its shared main identity exactly like the main.
    addr_hit_w = cmd_bcast_i || (cmd_addr_i == main_id_w);
    run_w      = cmd_valid_i && addr_hit_w;
  end

  // -----------------------------------------------------------------
  // Program change path
  // -----------------------------------------------------------------
  // The instrument port feeds only the recall decoder; nothing goes back.
  rrlc_recall_if rif ();
  assign rif.prog_valid = prog_valid_i;
  assign rif.prog_data  = prog_data_i;
  assign rif.enable     = master_w;

  rrlc_prog_decode u_dec (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .rif        (rif)
  );

  // -----------------------------------------------------------------
  // Lock control
  // -----------------------------------------------------------------
  logic locked_w;
  logic lsh_w;
  logic ush_w;

  // Remote commands keep running while the panel is locked.
  rrlc_lock_ctrl #(
    .CONFIRM_CYCLES (CONFIRM_CYCLES)
  ) u_lock (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .cmd_valid_i   (run_w),
    .cmd_i         (cmd_i),
    .pw_i          (cmd_pw_i),
    .locked_o      (locked_w),
    .lock_show_o   (lsh_w),
    .unlock_show_o (ush_w)
  );

  // -----------------------------------------------------------------
  // Output registers
  // -----------------------------------------------------------------
  logic       tx_reg,    tx_next;
  logic       txoe_reg,  txoe_next;
  logic       rep_reg,   rep_next;
  logic       exec_reg,  exec_next;
  logic [4:0] keys_reg,  keys_next;
  logic       shl_reg,   shl_next;

  always_comb begin
    // A master re-sends host data onto the multidrop pair; a slave forwards
    // its multidrop input unchanged in value but retimed through the same output register.
    tx_next   = master_w ? host_rx_i : mdrop_rx_i;
    txoe_next = 1'b1;
    // Shadows stay silent so the host never discovers them.
    rep_next  = reply_req_i && !shadow_w && addr_hit_w && !cmd_bcast_i;
    exec_next = run_w;
    keys_next = locked_w ? 5'h00 : panel_keys_i;
    shl_next  = shadow_w;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_reg   <= 1'b1;
      txoe_reg <= 1'b0;
      rep_reg  <= 1'b0;
      exec_reg <= 1'b0;
      keys_reg <= 5'h00;
      shl_reg  <= 1'b0;
    end else begin
      tx_reg   <= tx_next;
      txoe_reg <= txoe_next;
      rep_reg  <= rep_next;
      exec_reg <= exec_next;
      keys_reg <= keys_next;
      shl_reg  <= shl_next;
    end
  end

  assign mdrop_tx_o    = tx_reg;
  assign mdrop_tx_oe_o = txoe_reg;
  assign reply_en_o    = rep_reg;
  assign cmd_exec_o    = exec_reg;
  assign panel_keys_o  = keys_reg;
  assign shadow_led_o  = shl_reg;
  assign recall_stb_o  = rif.recall_stb;
  assign recall_in_o   = rif.recall_in;
  assign recall_xo_o   = rif.recall_xo;
  assign recall_num_o  = rif.recall_num;
  assign locked_o      = locked_w;
  assign lock_show_o   = lsh_w;
  assign unlock_show_o = ush_w;

  AST_SLAVE_NO_RECALL: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (prog_valid_i && is_slave(interface_sel_i)) |=> !recall_stb_o)
    else $error("Slave unit acted on program change.");
  AST_SHADOW_SILENT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    shadow_w |=> !reply_en_o)
    else $error("Shadow unit enabled a reply.");
  AST_LOCK_BLOCKS_KEYS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    locked_w |=> panel_keys_o == 5'h00)
    else $error("Panel key passed while locked.");
  AST_SHADOW_EXECS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cmd_valid_i && shadow_w && cmd_addr_i == ID_W'(unit_identity_i - ID_MAIN_MAX)) |=> cmd_exec_o)
    else $error("Shadow ignored its main identity.");
  AST_RELAY: assert property (@(posedge core_clk_i) disable iff (rst_i)
    master_w |=> mdrop_tx_o == $past(host_rx_i))
    else $error("Master did not relay host data.");
endmodule
`default_nettype wire

//--- hdl/rrlc_pkg.sv
// Functional notes
// - Program 1..40 recalls input memory of the same number.
// - Program 65..73 recalls input and crossover memory 1..9 together.
// - Program 97..105 recalls crossover memory 1..9 only.
// - Any other program number is ignored, nothing changes.
// - Instrument port only receives, only recalls; no control, metering or replies.
// - Program changes act only in master interface settings; slaves ignore them.
// - Shadow unit executes commands addressed to the shared main identity.
// - Shadow unit never transmits settings or replies to the host.
// - Shadow identities only in slave settings 06-08, after 32, shadow lamp lit.
// - Multidrop input passes to multidrop output (slave settings) retimed by one register stage.
// - Master relays host traffic to slaves; slave point-to-point ports unused.
// - Host data from the point-to-point port is re-sent onto the multidrop link.
// - Lock command disables all panel controls, mute and quick recall keys included.
// - Password carried by a lock command is stored for later unlock compares.
// - While locked, remote host commands are still executed.
// - Shadow units apply broadcast lock along with main units.
// - Matching unlock releases the panel and briefly shows a confirmation code.
// - No universal password; only the stored password unlocks.
`default_nettype none
package rrlc_pkg;
  localparam int          PW_W          = 32;
  localparam int          ID_W          = 6;
  localparam logic [7:0]  PROG_IN_LO    = 8'h01;
  localparam logic [7:0]  PROG_IN_HI    = 8'h28;
  localparam logic [7:0]  PROG_BOTH_LO  = 8'h41;
  localparam logic [7:0]  PROG_BOTH_HI  = 8'h49;
  localparam logic [7:0]  PROG_XO_LO    = 8'h61;
  localparam logic [7:0]  PROG_XO_HI    = 8'h69;
  localparam logic [3:0]  IF_SLAVE_LO   = 4'h6;
  localparam logic [3:0]  IF_SLAVE_HI   = 4'h8;
  localparam logic [3:0]  IF_MASTER_HI  = 4'h5;
  localparam logic [3:0]  IF_MASTER_WL  = 4'h9;
  localparam logic [ID_W-1:0] ID_MAIN_MAX = 6'h20;
  localparam int          CONFIRM_NS    = 1000000;
  localparam int          CLK_NS        = 10;
  localparam int          CONFIRM_CYC   = CONFIRM_NS / CLK_NS;
  localparam logic [PW_W-1:0] PW_RESET  = 32'h0000_0000;
  typedef enum logic [1:0] {
    RRLC_CMD_NONE,
    RRLC_CMD_LOCK,
    RRLC_CMD_UNLOCK,
    RRLC_CMD_OTHER
  } rrlc_cmd_t;
endpackage
`default_nettype wire

//--- hdl/rrlc_recall_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rrlc_recall_if;
  logic       prog_valid;
  logic [6:0] prog_data;
  logic       enable;
  logic       recall_in;
  logic       recall_xo;
  logic [5:0] recall_num;
  logic       recall_stb;
  modport dec (input prog_valid, prog_data, enable, output recall_in, recall_xo, recall_num, recall_stb);
  modport top (output prog_valid, prog_data, enable, input recall_in, recall_xo, recall_num, recall_stb);
endinterface
`default_nettype wire

//--- hdl/rrlc_prog_decode.sv
`timescale 1ns/1ps
`default_nettype none
module rrlc_prog_decode (
  input  wire logic   core_clk_i,
  input  wire logic   rst_i,
  rrlc_recall_if.dec  rif
);
  import rrlc_pkg::*;
  logic       stb_reg,  stb_next;
  logic       in_reg,   in_next;
  logic       xo_reg,   xo_next;
  logic [5:0] num_reg,  num_next;
  logic [7:0] prog;

  // -----------------------------------------------------------------
  // Program number decode
  // -----------------------------------------------------------------
  always_comb begin
    prog     = {1'b0, rif.prog_data} + 8'h01;
    stb_next = 1'b0;
    in_next  = in_reg;
    xo_next  = xo_reg;
    num_next = num_reg;
    if (rif.prog_valid && rif.enable) begin
      if (prog >= PROG_IN_LO && prog <= PROG_IN_HI) begin
        stb_next = 1'b1;
        in_next  = 1'b1;
        xo_next  = 1'b0;
        num_next = prog[5:0];
      end else if (prog >= PROG_BOTH_LO && prog <= PROG_BOTH_HI) begin
        stb_next = 1'b1;
        in_next  = 1'b1;
        xo_next  = 1'b1;
        num_next = 6'(prog - PROG_BOTH_LO + 8'h01);
      end else if (prog >= PROG_XO_LO && prog <= PROG_XO_HI) begin
        stb_next = 1'b1;
        in_next  = 1'b0;
        xo_next  = 1'b1;
        num_next = 6'(prog - PROG_XO_LO + 8'h01);
      end
      // Other numbers fall through: no strobe, and in, xo and number keep their values.
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_reg <= 1'b0;
      in_reg  <= 1'b0;
      xo_reg  <= 1'b0;
      num_reg <= 6'h00;
    end else begin
      stb_reg <= stb_next;
      in_reg  <= in_next;
      xo_reg  <= xo_next;
      num_reg <= num_next;
    end
  end

  assign rif.recall_stb = stb_reg;
  assign rif.recall_in  = in_reg;
  assign rif.recall_xo  = xo_reg;
  assign rif.recall_num = num_reg;

  AST_IGNORE_OTHER: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rif.prog_valid && rif.enable && rif.prog_data > 7'h27 && rif.prog_data < 7'h40) |=> !stb_reg)
    else $error("Out-of-range program produced a recall.");
  AST_BOTH_MAP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rif.prog_valid && rif.enable && rif.prog_data == 7'h40) |=> (stb_reg && in_reg && xo_reg && num_reg == 6'h01))
    else $error("Program 65 did not recall both memories 1.");
endmodule
`default_nettype wire

//--- hdl/rrlc_lock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rrlc_lock_ctrl #(
  parameter int CONFIRM_CYCLES = rrlc_pkg::CONFIRM_CYC
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cmd_valid_i,
  input  wire rrlc_pkg::rrlc_cmd_t       cmd_i,
  input  wire logic [rrlc_pkg::PW_W-1:0] pw_i,
  output logic                           locked_o,
  output logic                           lock_show_o,
  output logic                           unlock_show_o
);
  import rrlc_pkg::*;
  logic            locked_reg, locked_next;
  logic [PW_W-1:0] pw_reg,     pw_next;
  logic [31:0]     cnt_reg,    cnt_next;
  logic            lsh_reg,    lsh_next;
  logic            ush_reg,    ush_next;

  // -----------------------------------------------------------------
  // Lock state and stored password
  // -----------------------------------------------------------------
  always_comb begin
    locked_next = locked_reg;
    pw_next     = pw_reg;
    cnt_next    = (cnt_reg != 32'h0000_0000) ? cnt_reg - 32'h0000_0001 : cnt_reg;
    lsh_next    = lsh_reg && (cnt_reg > 32'h0000_0001);
    ush_next    = ush_reg && (cnt_reg > 32'h0000_0001);
    if (cmd_valid_i && cmd_i == RRLC_CMD_LOCK) begin
      locked_next = 1'b1;
      pw_next     = pw_i;
      lsh_next    = 1'b1;
      ush_next    = 1'b0;
      cnt_next    = 32'(CONFIRM_CYCLES);
    end else if (cmd_valid_i && cmd_i == RRLC_CMD_UNLOCK && locked_reg) begin
      // No master password exists: only an exact match releases.
      if (pw_i == pw_reg) begin
        locked_next = 1'b0;
        ush_next    = 1'b1;
        lsh_next    = 1'b0;
        cnt_next    = 32'(CONFIRM_CYCLES);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_reg <= 1'b0;
      pw_reg     <= PW_RESET;
      cnt_reg    <= 32'h0000_0000;
      lsh_reg    <= 1'b0;
      ush_reg    <= 1'b0;
    end else begin
      locked_reg <= locked_next;
      pw_reg     <= pw_next;
      cnt_reg    <= cnt_next;
      lsh_reg    <= lsh_next;
      ush_reg    <= ush_next;
    end
  end

  assign locked_o      = locked_reg;
  assign lock_show_o   = lsh_reg;
  assign unlock_show_o = ush_reg;

  AST_BAD_PW_KEEPS_LOCK: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == RRLC_CMD_UNLOCK && locked_reg && pw_i != pw_reg)
      |=> (locked_reg && pw_reg == $past(pw_reg)))
    else $error("Wrong password changed lock state.");
  AST_GOOD_PW_UNLOCKS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == RRLC_CMD_UNLOCK && locked_reg && pw_i == pw_reg) |=> (!locked_reg && ush_reg))
    else $error("Matching unlock did not release.");
  AST_LOCK_STORES: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == RRLC_CMD_LOCK) |=> (locked_reg && pw_reg == $past(pw_i)))
    else $error("Lock did not store password.");
endmodule
`default_nettype wire

//--- sim/rrlc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial line partner
// ----------------------------------------
// One host alone drives the point-to-point line.
// The multidrop line stands for a network of at most 32 units, one talker at a time.
// Both lines are redrawn at random every cycle, so a stale relayed bit matches only by chance, about half the time.
module rrlc_line_model (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output var  logic host_line_o,
  output var  logic mdrop_line_o
);
  integer seed = 32'h0000_4e21;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_line_o  <= 1'b1;
      mdrop_line_o <= 1'b1;
    end else begin
      {mdrop_line_o, host_line_o} <= 2'($random(seed));
    end
  end
endmodule
`default_nettype wire

//--- sim/rrlc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rrlc_top_tb;
  import rrlc_pkg::*;
  localparam int SHOW = 4;
  logic clk = 1'b0, rst = 1'b1, pv = 1'b0, cv = 1'b0, cb = 1'b0, rreq = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [5:0]  ident = 6'h05, caddr = 6'h00;
  logic [6:0]  pd = 7'h00, d;
  logic [4:0]  keys = 5'h00;
  logic [31:0] pw = 32'h0000_0000, pwv;
  logic [8:0]  e, last;
  logic        b;
  rrlc_cmd_t   cmd = RRLC_CMD_NONE;
  wire logic   host_line, mdrop_line, mtx, moe, ren, cex, stb, rin, rxo, lck, sled, lsh, ush;
  wire logic [5:0] rnum;
  wire logic [4:0] kout;
  integer seed = 32'h8185, mismatches = 0, tests_run = 0, i, k;
  always #5 clk = ~clk;
  rrlc_line_model rrlc_line_model_i (.core_clk_i(clk), .rst_i(rst), .host_line_o(host_line),
    .mdrop_line_o(mdrop_line));
  rrlc_top #(.CONFIRM_CYCLES(SHOW)) rrlc_top_i (.core_clk_i(clk), .rst_i(rst), .interface_sel_i(sel),
    .unit_identity_i(ident), .prog_valid_i(pv), .prog_data_i(pd), .host_rx_i(host_line),
    .mdrop_rx_i(mdrop_line), .cmd_valid_i(cv), .cmd_addr_i(caddr), .cmd_bcast_i(cb), .cmd_i(cmd),
    .cmd_pw_i(pw), .reply_req_i(rreq), .panel_keys_i(keys), .mdrop_tx_o(mtx), .mdrop_tx_oe_o(moe),
    .reply_en_o(ren), .cmd_exec_o(cex), .recall_stb_o(stb), .recall_in_o(rin), .recall_xo_o(rxo),
    .recall_num_o(rnum), .panel_keys_o(kout), .locked_o(lck), .shadow_led_o(sled),
    .lock_show_o(lsh), .unlock_show_o(ush));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic prog(input logic [6:0] v);
    @(posedge clk);
    pv <= 1'b1;
    pd <= v;
    @(posedge clk);
    pv <= 1'b0;
    #1;
  endtask
  task automatic send(input rrlc_cmd_t c, input logic [5:0] a, input logic bc, input logic [31:0] p);
    @(posedge clk);
    cv <= 1'b1;
    cmd <= c;
    caddr <= a;
    cb <= bc;
    pw <= p;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask
  // Program number is the data byte plus one; the memory number restarts in each range.
  function automatic logic [8:0] exp_recall(input logic [6:0] v);
    logic [7:0] p;
    p = {1'b0, v} + 8'h01;
    if (p >= PROG_IN_LO && p <= PROG_IN_HI) exp_recall = {3'b110, p[5:0]};
    else if (p >= PROG_BOTH_LO && p <= PROG_BOTH_HI) exp_recall = {3'b111, p[5:0] - 6'h00};
    else if (p >= PROG_XO_LO && p <= PROG_XO_HI) exp_recall = {3'b101, p[5:0] - 6'h20};
    else exp_recall = 9'h000;
  endfunction
  task automatic chk_recall(input logic want);
    e = want ? exp_recall(d) : 9'h000;
    prog(d);
    chk(stb, e[8]);
    if (e[8]) last = e;
    chk({rin, rxo, rnum}, last[7:0]);
    chk(ren | cex, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin #200_000; mismatches++; conclude(); end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk(mtx, 1'b1);
    chk(lck, 1'b0);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    last = 9'h000;
    for (i = 0; i < 192; i++) begin
      k = $unsigned($random(seed)) % 7;
      sel <= (i < 128 || k == 6) ? 4'h9 : k[3:0];
      d = (i < 128) ? i[6:0] : 7'($random(seed));
      chk_recall(1'b1);
    end
    for (i = 0; i < 32; i++) begin
      sel <= IF_SLAVE_LO + 4'($unsigned($random(seed)) % 3);
      d = (i < 8) ? 7'h00 : 7'($random(seed));
      chk_recall(1'b0);
    end
    $display("test program change done");
    for (k = 0; k < 2; k++) begin
      sel <= k ? 4'h8 : 4'h4;
      repeat (2) @(posedge clk);
      for (i = 0; i < 16; i++) begin
        @(negedge clk);
        b = k ? mdrop_line : host_line;
        @(posedge clk);
        #1;
        chk(mtx, b);
        chk(moe, 1'b1);
      end
    end
    $display("test relay done");
    sel <= 4'h0;
    ident <= 6'd37;
    rreq <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(sled, 1'b0);
    sel <= IF_SLAVE_LO;
    repeat (2) @(posedge clk);
    #1;
    chk(sled, 1'b1);
    send(RRLC_CMD_OTHER, 6'd5, 1'b0, 32'h0000_0000);
    chk(cex, 1'b1);
    chk(ren, 1'b0);
    send(RRLC_CMD_OTHER, 6'd6, 1'b0, 32'h0000_0000);
    chk(cex, 1'b0);
    $display("test shadow done");
    // Top bit forced so the reset password can never match by chance.
    pwv = $random(seed) | 32'h8000_0000;
    keys <= 5'h1f;
    send(RRLC_CMD_LOCK, 6'd0, 1'b1, pwv);
    chk({lck, lsh}, 2'b11);
    @(posedge clk);
    #1;
    chk(kout, 5'h00);
    repeat (SHOW - 2) @(posedge clk);
    #1;
    chk(lsh, 1'b1);
    @(posedge clk);
    #1;
    chk(lsh, 1'b0);
    send(RRLC_CMD_OTHER, 6'd5, 1'b0, 32'h0000_0000);
    chk(cex, 1'b1);
    send(RRLC_CMD_UNLOCK, 6'd5, 1'b0, pwv ^ 32'h0000_0001);
    chk({lck, ush}, 2'b10);
    send(RRLC_CMD_UNLOCK, 6'd5, 1'b0, PW_RESET);
    chk({lck, ush}, 2'b10);
    send(RRLC_CMD_UNLOCK, 6'd5, 1'b0, pwv);
    chk({lck, ush}, 2'b01);
    @(posedge clk);
    #1;
    chk(kout, 5'h1f);
    repeat (SHOW - 1) @(posedge clk);
    #1;
    chk(ush, 1'b0);
    ident <= 6'd5;
    send(RRLC_CMD_OTHER, 6'd5, 1'b0, 32'h0000_0000);
    chk(ren, 1'b1);
    chk(sled, 1'b0);
    $display("test lock done");
    conclude();
  end
endmodule
`default_nettype wire
